// file: led_drive_checker.sv
`timescale 1ns/100ps
`default_nettype none
module led_drive_checker (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // Host side
  input wire logic WR_STROBE_IN,
  input wire logic [7:0] WR_ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic SEQ_SYNC_REQUEST_IN,
  input wire logic LINE_TRANSFER_GATE_IN,
  input wire logic MONO_MODE_IN,
  input wire logic [1:0] SEQUENCE_LENGTH_IN,
  // Matrix side and status
  input wire logic [2:0] LED_SWITCH_OUT,
  input wire logic SHUNT_SWITCH_OUT,
  input wire logic BLANKING_OUT,
  input wire logic [7:0] DAC_CODE_OUT,
  input wire logic [1:0] SEQ_STATE_OUT,
  input wire logic SEQ_RUNNING_OUT,
  input wire logic BLANK_DISABLED_OUT,
  input wire logic [7:0] OPERATING_MODE_OUT,
  input wire logic CONFIG_DEFAULTS_OUT
);
  // ==========================================================
  // Decoding
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  logic test_mode, wr_norm, colour_go, at_end;
  assign test_mode = OPERATING_MODE_OUT == 8'ha3;
  assign wr_norm = WR_STROBE_IN && !test_mode && WR_DATA_IN == 8'h00;
  assign colour_go = !SEQ_SYNC_REQUEST_IN && !MONO_MODE_IN && SEQ_RUNNING_OUT;
  assign at_end = SEQ_STATE_OUT == SEQUENCE_LENGTH_IN;
  // ==========================================================
  // Assertions
  AST_TEST_ENTER: assert property (WR_STROBE_IN && WR_ADDR_IN == 8'h01
    && WR_DATA_IN == 8'ha3 |=> OPERATING_MODE_OUT == 8'ha3)
    else $error("test mode not entered");
  AST_REDIRECT: assert property (WR_STROBE_IN && test_mode
    && WR_ADDR_IN == 8'h04 |=> !CONFIG_DEFAULTS_OUT && test_mode)
    else $error("write not redirected in test mode");
  AST_BLANK_OFF: assert property (WR_STROBE_IN && test_mode
    && WR_ADDR_IN == 8'h24 && WR_DATA_IN == 8'h1c |=> BLANK_DISABLED_OUT)
    else $error("blanking not disabled");
  AST_GLOBAL_RST: assert property (wr_norm && WR_ADDR_IN == 8'h04
    |=> CONFIG_DEFAULTS_OUT && OPERATING_MODE_OUT == 8'h23
    && !BLANK_DISABLED_OUT ##1 !CONFIG_DEFAULTS_OUT)
    else $error("global reset write mishandled");
  AST_SEQ_RST: assert property (wr_norm && WR_ADDR_IN == 8'h2f
    |=> !SEQ_RUNNING_OUT && SEQ_STATE_OUT == 2'h0
    && $stable(BLANK_DISABLED_OUT) && $stable(OPERATING_MODE_OUT))
    else $error("sequencer reset mishandled");
  AST_PATH: assert property ((|LED_SWITCH_OUT) || SHUNT_SWITCH_OUT)
    else $error("drive current has no path");
  AST_SHUNT_LAST: assert property ($fell(SHUNT_SWITCH_OUT)
    |-> $past(LED_SWITCH_OUT) != 3'h0 && LED_SWITCH_OUT != 3'h0)
    else $error("shunt opened before led closed");
  AST_LED_LAST: assert property (LED_SWITCH_OUT == 3'h0
    && $past(LED_SWITCH_OUT) != 3'h0 |-> $past(SHUNT_SWITCH_OUT))
    else $error("led opened before shunt closed");
  AST_DAC_DARK: assert property ($changed(DAC_CODE_OUT)
    |-> LED_SWITCH_OUT == 3'h0 && SHUNT_SWITCH_OUT)
    else $error("dac changed while an led was lit");
  AST_ONE_LED: assert property ($onehot0(LED_SWITCH_OUT))
    else $error("two led switches closed");
  AST_START: assert property (SEQ_SYNC_REQUEST_IN
    && LINE_TRANSFER_GATE_IN |=> SEQ_STATE_OUT == 2'h0 && SEQ_RUNNING_OUT)
    else $error("sequence not restarted");
  AST_ADVANCE: assert property ($rose(LINE_TRANSFER_GATE_IN)
    && colour_go && !at_end |=> SEQ_STATE_OUT == $past(SEQ_STATE_OUT) + 2'h1)
    else $error("colour advance wrong");
  AST_FINAL_HOLD: assert property ($rose(LINE_TRANSFER_GATE_IN)
    && colour_go && at_end |=> !SEQ_RUNNING_OUT && $stable(SEQ_STATE_OUT)
    ##[1:8] LED_SWITCH_OUT == 3'h0)
    else $error("final state not held dark");
  AST_BLANK_DARK: assert property (BLANKING_OUT
    && LED_SWITCH_OUT == 3'h0 |=> LED_SWITCH_OUT == 3'h0)
    else $error("led closed during blanking");
  // ==========================================================
  // Coverage
  cover property (SEQ_SYNC_REQUEST_IN && LINE_TRANSFER_GATE_IN);
  cover property ($fell(SHUNT_SWITCH_OUT));
  cover property (CONFIG_DEFAULTS_OUT);
  cover property (MONO_MODE_IN && SEQ_RUNNING_OUT && $changed(SEQ_STATE_OUT));
endmodule : led_drive_checker

bind led_drive_switch_pwm_control led_drive_checker i_chk (
  .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .WR_STROBE_IN(WR_STROBE_IN),
  .WR_ADDR_IN(WR_ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
  .SEQ_SYNC_REQUEST_IN(SEQ_SYNC_REQUEST_IN),
  .LINE_TRANSFER_GATE_IN(LINE_TRANSFER_GATE_IN), .MONO_MODE_IN(MONO_MODE_IN),
  .SEQUENCE_LENGTH_IN(SEQUENCE_LENGTH_IN), .LED_SWITCH_OUT(LED_SWITCH_OUT),
  .SHUNT_SWITCH_OUT(SHUNT_SWITCH_OUT), .DAC_CODE_OUT(DAC_CODE_OUT),
  .BLANKING_OUT(BLANKING_OUT),
  .SEQ_STATE_OUT(SEQ_STATE_OUT), .SEQ_RUNNING_OUT(SEQ_RUNNING_OUT),
  .BLANK_DISABLED_OUT(BLANK_DISABLED_OUT),
  .OPERATING_MODE_OUT(OPERATING_MODE_OUT),
  .CONFIG_DEFAULTS_OUT(CONFIG_DEFAULTS_OUT));
`default_nettype wire

// file: led_drive_pkg.sv
// How it works
// - Separate current per colour and modulation per state.
// - Modulation switching allowed anywhere in line.
// - Slew switch: shunt, DAC zero, load, LED.
// - During DAC change only shunt carries current.
// - Writing a3 to 01 enters test mode.
// - Test write 1c to 24 forces red level.
// - Normal write 00 to 04 restores default configuration.
// - Normal write 00 to 2f resets only sequencer.
// - Steering is make-before-break, DAC unchanged.
// - Each state has own modulation settings.
// - Divider divides clock, advances period counter.
// - Period counter wraps to zero after period.
// - Output high while counter below duty.
// - Each wrap advances enable-cycle counter until it saturates at full.
// - Gate opens at start, closes at stop.
// - Divider 4 bits, period and duty 12.
// - Colour: sync resets, gate pulses advance state.
// - Mono: advance at enable end, hold final.
package led_drive_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFF_OPERATING_CONFIG_MODE = 8'h01;
  localparam logic [7:0] OFF_GLOBAL_SOFTWARE_RESET = 8'h04;
  localparam logic [7:0] OFF_EXTENDED_PAGE_RECONFIG = 8'h24;
  localparam logic [7:0] OFF_LED_SEQUENCER_RESET = 8'h2f;

  // ==========================================================
  // Data codes and reset values
  localparam logic [7:0] MODE_TEST_CONFIG = 8'ha3;
  localparam logic [7:0] MODE_NORMAL = 8'h23;
  localparam logic [7:0] MODE_RESET = 8'h23;
  localparam logic [7:0] EXT_FORCE_RED_LEVEL = 8'h1c;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] RESET_TRIGGER_CODE = 8'h00;

  // ==========================================================
  // Field widths
  localparam int DIV_W = 4;
  localparam int CNT_W = 12;
  localparam int EN_W = 8;
  localparam int LEVEL_W = 8;
  localparam int RANGE_W = 2;
  localparam int STATES = 4;

  // ==========================================================
  // LED selection codes per sequence state
  localparam logic [1:0] LED_NONE = 2'h0;
  localparam logic [1:0] LED_RED = 2'h1;
  localparam logic [1:0] LED_GREEN = 2'h2;
  localparam logic [1:0] LED_BLUE = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DAC_SETTLE_NS = 500;
  localparam int DAC_SETTLE_CYC =
    (DAC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SL_IDLE,
    SL_DRAIN,
    SL_ZERO,
    SL_LOAD
  } slew_state_t;

endpackage : led_drive_pkg

// file: led_drive_switch_pwm_control.sv
`timescale 1ns/100ps
`default_nettype none
module led_drive_switch_pwm_control
  import led_drive_pkg::*;
#(
  parameter int SETTLE_CYCLES = led_drive_pkg::DAC_SETTLE_CYC
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // Register writes from the serial interface
  input wire logic WR_STROBE_IN,
  input wire logic [7:0] WR_ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  // Sequence timing
  input wire logic SEQ_SYNC_REQUEST_IN,
  input wire logic LINE_TRANSFER_GATE_IN,
  input wire logic MONO_MODE_IN,
  // Sequence configuration
  input wire logic [1:0] SEQUENCE_LENGTH_IN,
  input wire logic [2*led_drive_pkg::STATES-1:0] STATE_LED_SELECT_IN,
  // Per-state modulation configuration
  input wire logic [16-1:0] MOD_CLOCK_DIVIDER_IN,
  input wire logic [48-1:0] MOD_PERIOD_VALUE_IN,
  input wire logic [48-1:0] MOD_DUTY_VALUE_IN,
  input wire logic [32-1:0] GATE_START_COUNT_IN,
  input wire logic [32-1:0] GATE_STOP_COUNT_IN,
  // Per-colour current configuration
  input wire logic [7:0] RED_CURRENT_LEVEL_IN,
  input wire logic [7:0] GREEN_CURRENT_LEVEL_IN,
  input wire logic [7:0] BLUE_CURRENT_LEVEL_IN,
  input wire logic [5:0] CURRENT_DAC_RANGE_IN,
  // Switch matrix and current DAC
  output logic [2:0] LED_SWITCH_OUT,
  output logic SHUNT_SWITCH_OUT,
  output logic [7:0] DAC_CODE_OUT,
  output logic [1:0] DAC_RANGE_OUT,
  output logic BLANKING_OUT,
  // Status
  output logic [1:0] SEQ_STATE_OUT,
  output logic SEQ_RUNNING_OUT,
  output logic BLANK_DISABLED_OUT,
  output logic [7:0] OPERATING_MODE_OUT,
  output logic CONFIG_DEFAULTS_OUT
);

  import led_drive_pkg::*;

  // ==========================================================
  // Parameter check
  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad
      $error("led_drive: SETTLE_CYCLES out of range");
    end
    // The per-state port slices are cut for these field widths only.
    if (DIV_W != 4 || CNT_W != 12 || EN_W != 8) begin : g_width
      $error("led_drive: field widths do not match the ports");
    end
  endgenerate

  logic [7:0] mode_q;
  logic [7:0] ext_q;
  logic blank_dis_q;
  logic defaults_q;
  logic [1:0] seq_q;
  logic run_q;
  logic tg_prev_q;
  logic done_prev_q;
  slew_state_t sl_q;
  logic [7:0] settle_q;
  logic [2:0] led_q;
  logic shunt_q;
  logic [7:0] dac_q;
  logic [1:0] rng_q;
  logic pwm_cmp;
  logic pwm_gate;
  logic pwm_done;

  // ==========================================================
  // Register write decode
  wire test_mode = (mode_q == MODE_TEST_CONFIG);
  wire wr_mode = WR_STROBE_IN && (WR_ADDR_IN == OFF_OPERATING_CONFIG_MODE);
  // While in test mode every other address lands in the extended page.
  wire wr_ext = WR_STROBE_IN && test_mode && !wr_mode;
  wire blank_set = wr_ext && (WR_ADDR_IN == OFF_EXTENDED_PAGE_RECONFIG)
    && (WR_DATA_IN == EXT_FORCE_RED_LEVEL);
  wire wr_norm = WR_STROBE_IN && !test_mode;
  wire soft_rst = wr_norm && (WR_ADDR_IN == OFF_GLOBAL_SOFTWARE_RESET)
    && (WR_DATA_IN == RESET_TRIGGER_CODE);
  wire seq_rst = wr_norm && (WR_ADDR_IN == OFF_LED_SEQUENCER_RESET)
    && (WR_DATA_IN == RESET_TRIGGER_CODE);

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mode_q <= MODE_RESET;
      ext_q <= EXT_RESET;
      blank_dis_q <= 1'b0;
      defaults_q <= 1'b0;
    end else begin
      defaults_q <= soft_rst;
      if (soft_rst) begin
        mode_q <= MODE_RESET;
        ext_q <= EXT_RESET;
        blank_dis_q <= 1'b0;
      end else begin
        if (wr_mode) begin
          mode_q <= WR_DATA_IN;
        end
        if (wr_ext) begin
          ext_q <= WR_DATA_IN;
        end
        if (blank_set) begin
          blank_dis_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Sequence progression
  // Inputs are synchronous, so a one-flop edge detect is enough.
  wire tg_rise = LINE_TRANSFER_GATE_IN && !tg_prev_q;
  wire start = SEQ_SYNC_REQUEST_IN && LINE_TRANSFER_GATE_IN;
  wire done_rise = pwm_done && !done_prev_q;
  wire step_col = tg_rise && !SEQ_SYNC_REQUEST_IN;
  wire step = MONO_MODE_IN ? done_rise : step_col;
  wire at_last = (seq_q == SEQUENCE_LENGTH_IN);
  wire seq_clr = soft_rst || seq_rst;
  // A restart outranks an advance that lands in the same cycle.
  wire advance = run_q && step && !at_last && !start;
  wire state_chg = !seq_clr && (start || advance);

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tg_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      tg_prev_q <= LINE_TRANSFER_GATE_IN;
      done_prev_q <= pwm_done;
    end
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      seq_q <= 2'h0;
      run_q <= 1'b0;
    end else if (seq_clr) begin
      seq_q <= 2'h0;
      run_q <= 1'b0;
    end else if (start) begin
      seq_q <= 2'h0;
      run_q <= 1'b1;
    end else if (run_q && step) begin
      if (at_last) begin
        run_q <= 1'b0;
      end else begin
        seq_q <= seq_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // Per-state selection
  wire [1:0] led_code = STATE_LED_SELECT_IN[seq_q*2 +: 2];
  wire [DIV_W-1:0] div_sel = MOD_CLOCK_DIVIDER_IN[seq_q*DIV_W +: DIV_W];
  wire [CNT_W-1:0] per_sel = MOD_PERIOD_VALUE_IN[seq_q*CNT_W +: CNT_W];
  wire [CNT_W-1:0] duty_sel = MOD_DUTY_VALUE_IN[seq_q*CNT_W +: CNT_W];
  wire [EN_W-1:0] start_sel = GATE_START_COUNT_IN[seq_q*EN_W +: EN_W];
  wire [EN_W-1:0] stop_sel = GATE_STOP_COUNT_IN[seq_q*EN_W +: EN_W];
  wire [2:0] led_onehot = (led_code == LED_RED) ? 3'h1 :
    (led_code == LED_GREEN) ? 3'h2 :
    (led_code == LED_BLUE) ? 3'h4 : 3'h0;
  wire [7:0] level_sel = (led_code == LED_RED) ? RED_CURRENT_LEVEL_IN :
    (led_code == LED_GREEN) ? GREEN_CURRENT_LEVEL_IN :
    (led_code == LED_BLUE) ? BLUE_CURRENT_LEVEL_IN : 8'h00;
  // A state coded off keeps the last range, so the DAC output holds still.
  wire [1:0] range_sel = (led_code == LED_RED) ? CURRENT_DAC_RANGE_IN[1:0] :
    (led_code == LED_GREEN) ? CURRENT_DAC_RANGE_IN[3:2] :
    (led_code == LED_BLUE) ? CURRENT_DAC_RANGE_IN[5:4] : rng_q;

  // ==========================================================
  // Modulation unit, restarted on every state change
  mod_pwm_unit #(
    .DIV_W(DIV_W),
    .CNT_W(CNT_W),
    .EN_W(EN_W)
  ) u_pwm (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .clear_in(state_chg || !run_q),
    .divider_in(div_sel),
    .period_in(per_sel),
    .duty_in(duty_sel),
    .start_in(start_sel),
    .stop_in(stop_sel),
    .compare_out(pwm_cmp),
    .gate_out(pwm_gate),
    .done_out(pwm_done)
  );

  // ==========================================================
  // Slew-limited switch sequencing
  // With blanking disabled a state change only moves the LED switches.
  wire slew_go = state_chg && !blank_dis_q;
  wire drained = (led_q == 3'h0) && shunt_q;
  wire settle_end = (settle_q == 8'h00);

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sl_q <= SL_IDLE;
      settle_q <= 8'h00;
    end else if (seq_clr) begin
      sl_q <= SL_IDLE;
      settle_q <= 8'h00;
    end else if (slew_go) begin
      sl_q <= SL_DRAIN;
    end else begin
      unique case (sl_q)
        SL_IDLE: begin
          settle_q <= 8'h00;
        end
        SL_DRAIN: begin
          if (drained) begin
            sl_q <= SL_ZERO;
            settle_q <= 8'(SETTLE_CYCLES - 1);
          end
        end
        SL_ZERO: begin
          if (settle_end) begin
            sl_q <= SL_LOAD;
            settle_q <= 8'(SETTLE_CYCLES - 1);
          end else begin
            settle_q <= settle_q - 8'h01;
          end
        end
        SL_LOAD: begin
          if (settle_end) begin
            sl_q <= SL_IDLE;
          end else begin
            settle_q <= settle_q - 8'h01;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Current DAC
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dac_q <= 8'h00;
      rng_q <= 2'h0;
    end else if (blank_dis_q) begin
      // Held fixed so that steering alone never disturbs the video.
      dac_q <= RED_CURRENT_LEVEL_IN;
    end else if (sl_q == SL_DRAIN && drained) begin
      dac_q <= 8'h00;
    end else if (sl_q == SL_ZERO && settle_end) begin
      dac_q <= level_sel;
      rng_q <= range_sel;
    end
  end

  // ==========================================================
  // Make-before-break switch steering
  // Modulation may toggle the LED at any cycle of a line.
  wire blank = (sl_q != SL_IDLE) || slew_go;
  wire lit = run_q && pwm_gate && pwm_cmp;
  wire [2:0] want = (blank || !lit) ? 3'h0 : led_onehot;
  wire led_match = (led_q == want);
  // Moving from one LED to another always passes through all-off.

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      led_q <= 3'h0;
      shunt_q <= 1'b1;
    end else if (!led_match) begin
      if (!shunt_q) begin
        shunt_q <= 1'b1;
      end else begin
        led_q <= (led_q == 3'h0) ? want : 3'h0;
      end
    end else if (led_q != 3'h0) begin
      shunt_q <= 1'b0;
    end else begin
      shunt_q <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  assign LED_SWITCH_OUT = led_q;
  assign SHUNT_SWITCH_OUT = shunt_q;
  assign DAC_CODE_OUT = dac_q;
  assign DAC_RANGE_OUT = rng_q;
  assign BLANKING_OUT = (sl_q != SL_IDLE);
  assign SEQ_STATE_OUT = seq_q;
  assign SEQ_RUNNING_OUT = run_q;
  assign BLANK_DISABLED_OUT = blank_dis_q;
  assign OPERATING_MODE_OUT = mode_q;
  assign CONFIG_DEFAULTS_OUT = defaults_q;

endmodule : led_drive_switch_pwm_control
`default_nettype wire

// file: led_matrix_model.sv
`timescale 1ns/100ps
`default_nettype none
module led_matrix_model (
  // Switch matrix and current DAC
  input wire logic [2:0] led_sw_in,
  input wire logic shunt_in,
  input wire logic [7:0] dac_in,
  // Light seen by the sensor
  output logic [2:0] lit_out,
  output logic [7:0] led_current_out
);
  // ==========================================================
  // Current division
  // A closed shunt is far lower in impedance than any diode, so it takes
  // the whole current and no LED glows even with its switch closed.
  assign lit_out = shunt_in ? 3'h0 : led_sw_in;
  assign led_current_out = (|lit_out) ? dac_in : 8'h00;
endmodule : led_matrix_model
`default_nettype wire

// file: mod_pwm_unit.sv
`timescale 1ns/100ps
`default_nettype none
module mod_pwm_unit #(
  parameter int DIV_W = 4,
  parameter int CNT_W = 12,
  parameter int EN_W = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic [DIV_W-1:0] divider_in,
  input wire logic [CNT_W-1:0] period_in,
  input wire logic [CNT_W-1:0] duty_in,
  input wire logic [EN_W-1:0] start_in,
  input wire logic [EN_W-1:0] stop_in,
  // Results
  output logic compare_out,
  output logic gate_out,
  output logic done_out
);

  // ==========================================================
  // Parameter check
  generate
    if (DIV_W < 1 || CNT_W < 2 || EN_W < 1) begin : g_bad
      $error("mod_pwm_unit: widths too small");
    end
  endgenerate

  logic [DIV_W-1:0] div_q;
  logic [CNT_W-1:0] cnt_q;
  logic [EN_W-1:0] en_q;
  logic cmp_q;
  logic gate_q;
  logic done_q;

  // ==========================================================
  // Decode
  // A divider of zero is served as one so the counter never stalls.
  wire tick = (div_q + 1'b1 >= divider_in) || (divider_in == '0);
  wire wrap = tick && (cnt_q >= period_in);
  wire [CNT_W-1:0] cnt_d = wrap ? '0 : cnt_q + (CNT_W)'(tick);
  wire en_full = (en_q == {EN_W{1'b1}});
  // The gate follows the next enable count, so it moves at the same edge
  // as the compare and the first enabled period is not cut short.
  wire [EN_W-1:0] en_d = (wrap && !en_full) ? en_q + 1'b1 : en_q;

  // ==========================================================
  // Counters
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= '0;
      cnt_q <= '0;
      en_q <= '0;
    end else if (clear_in) begin
      div_q <= '0;
      cnt_q <= '0;
      en_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end

  // ==========================================================
  // Compare and gate
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_q <= 1'b0;
      gate_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clear_in) begin
      cmp_q <= 1'b0;
      gate_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cmp_q <= (cnt_d < duty_in);
      if (en_d == stop_in) begin
        gate_q <= 1'b0;
        done_q <= 1'b1;
      end else if (en_d == start_in) begin
        gate_q <= 1'b1;
      end
    end
  end

  assign compare_out = cmp_q;
  assign gate_out = gate_q;
  assign done_out = done_q;

endmodule : mod_pwm_unit
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import led_drive_pkg::*;
  typedef struct {logic [2:0] led; logic [1:0] rng; logic [7:0] lvl; int per;}
    led_exp_t;
  logic mclk = 1'b0, rst = 1'b1, wr_stb = 1'b0, sync = 1'b0, gate = 1'b0;
  logic mono = 1'b0, pend = 1'b0, blank, shunt, running, bd, defaults;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, led_sel = 8'h00;
  logic [1:0] seq_len = 2'h2, dac_rng, state;
  logic [15:0] div = 16'h0;
  logic [47:0] per_v = '0, duty_v = '0;
  logic [31:0] start_c = '0, stop_c = '0;
  logic [7:0] lvl_r, lvl_g, lvl_b, dac, mode, cur;
  logic [5:0] rng;
  logic [2:0] led_sw, lit, lit_prev = 3'h0;
  int n_mismatch = 0, comparisons = 0, gap = 0;
  logic [15:0] reg_q[$];
  led_exp_t led_q[$];

  always #25 mclk = ~mclk;

  led_drive_switch_pwm_control #(.SETTLE_CYCLES(2)) i_dut (
    .MCLK_IN(mclk), .SYS_RST_IN(rst), .WR_STROBE_IN(wr_stb),
    .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data), .SEQ_SYNC_REQUEST_IN(sync),
    .LINE_TRANSFER_GATE_IN(gate), .MONO_MODE_IN(mono),
    .SEQUENCE_LENGTH_IN(seq_len), .STATE_LED_SELECT_IN(led_sel),
    .MOD_CLOCK_DIVIDER_IN(div), .MOD_PERIOD_VALUE_IN(per_v),
    .MOD_DUTY_VALUE_IN(duty_v), .GATE_START_COUNT_IN(start_c),
    .GATE_STOP_COUNT_IN(stop_c), .RED_CURRENT_LEVEL_IN(lvl_r),
    .GREEN_CURRENT_LEVEL_IN(lvl_g), .BLUE_CURRENT_LEVEL_IN(lvl_b),
    .CURRENT_DAC_RANGE_IN(rng), .LED_SWITCH_OUT(led_sw),
    .SHUNT_SWITCH_OUT(shunt), .DAC_CODE_OUT(dac), .DAC_RANGE_OUT(dac_rng),
    .BLANKING_OUT(blank), .SEQ_STATE_OUT(state), .SEQ_RUNNING_OUT(running),
    .BLANK_DISABLED_OUT(bd), .OPERATING_MODE_OUT(mode),
    .CONFIG_DEFAULTS_OUT(defaults));

  led_matrix_model i_far (.led_sw_in(led_sw), .shunt_in(shunt),
    .dac_in(dac), .lit_out(lit), .led_current_out(cur));

  // ==========================================================
  // Comparison and report
  task automatic cmp_reg(input logic [15:0] exp, input logic [15:0] act);
    comparisons++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t reg exp=%h act=%h", $time, exp, act);
    end
  endtask : cmp_reg

  task automatic cmp_led(input logic [28:0] exp, input logic [28:0] act);
    comparisons++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t led exp=%h act=%h", $time, exp, act);
    end
  endtask : cmp_led

  task final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Monitor
  always @(posedge mclk) pend <= wr_stb;

  always @(negedge mclk) begin : mon
    led_exp_t e;
    if (pend) cmp_reg(reg_q.pop_front(), {3'h0, defaults, bd, running, state,
      mode});
    gap++;
    if ((|lit) && !(|lit_prev)) begin
      if (led_q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] t=%0t led exp=%h act=%h", $time, 3'h0, lit);
      end else begin
        e = led_q.pop_front();
        cmp_led({e.led, e.rng, e.lvl, 16'(e.per)}, {lit, dac_rng, cur,
          (e.per == 0) ? 16'h0 : 16'(gap)});
      end
      gap = 0;
    end
    lit_prev = lit;
  end

  // ==========================================================
  // Stimulus
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [15:0] e);
    @(negedge mclk);
    wr_stb = 1'b1;
    wr_addr = a;
    wr_data = d;
    reg_q.push_back(e);
    @(negedge mclk);
    wr_stb = 1'b0;
  endtask : wr

  task automatic cfg(input int s, input logic [1:0] l, input logic [3:0] dv,
    input logic [11:0] p, input logic [11:0] dt, input logic [7:0] st,
    input logic [7:0] sp);
    led_sel[2*s +: 2] = l;
    div[4*s +: 4] = dv;
    per_v[12*s +: 12] = p;
    duty_v[12*s +: 12] = dt;
    start_c[8*s +: 8] = st;
    stop_c[8*s +: 8] = sp;
  endtask : cfg

  // A gate pulse is one cycle wide; sync rides on it only for a restart.
  task automatic pulse(input logic s, input int hold);
    @(negedge mclk);
    sync = s;
    gate = 1'b1;
    @(negedge mclk);
    sync = 1'b0;
    gate = 1'b0;
    repeat (hold) @(negedge mclk);
  endtask : pulse

  initial begin : main
    void'($urandom(32'hda6bfa8a));
    lvl_r = 8'($urandom);
    lvl_g = 8'($urandom);
    lvl_b = 8'($urandom);
    rng = 6'($urandom);
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    wr(8'h40, 8'($urandom), 16'h0023);
    wr(8'h01, 8'ha3, 16'h00a3);
    wr(8'h04, 8'h00, 16'h00a3);
    wr(8'h24, 8'h1c, 16'h08a3);
    wr(8'h01, 8'h23, 16'h0823);
    wr(8'h2f, 8'h00, 16'h0823);
    wr(8'h04, 8'h00, 16'h1023);
    cfg(0, LED_RED, 4'h3, 12'h007, 12'h002, 8'h01, 8'h04);
    cfg(1, LED_GREEN, 4'h0, 12'h009, 12'h000, 8'h00, 8'h03);
    cfg(2, LED_BLUE, 4'h2, 12'h004, 12'h005, 8'h00, 8'h04);
    cfg(3, 2'($urandom), 4'($urandom), 12'($urandom), 12'($urandom),
      8'($urandom), 8'($urandom));
    led_q.push_back('{3'h1, rng[1:0], lvl_r, 0});
    repeat (2) led_q.push_back('{3'h1, rng[1:0], lvl_r, 24});
    led_q.push_back('{3'h4, rng[5:4], lvl_b, 0});
    pulse(1'b1, 200);
    pulse(1'b0, 120);
    pulse(1'b0, 80);
    pulse(1'b0, 20);
    wr(8'h01, 8'ha3, 16'h02a3);
    wr(8'h24, 8'h1c, 16'h0aa3);
    wr(8'h01, 8'h23, 16'h0a23);
    mono = 1'b1;
    seq_len = 2'h1;
    cfg(1, LED_GREEN, 4'h0, 12'h009, 12'h004, 8'h01, 8'h03);
    led_q.push_back('{3'h1, rng[5:4], lvl_r, 0});
    repeat (2) led_q.push_back('{3'h1, rng[5:4], lvl_r, 24});
    led_q.push_back('{3'h2, rng[5:4], lvl_r, 0});
    led_q.push_back('{3'h2, rng[5:4], lvl_r, 10});
    pulse(1'b1, 160);
    wr(8'h2f, 8'h00, 16'h0823);
    comparisons++;
    if (led_q.size() != 0) begin
      n_mismatch++;
      $display("[ERR] t=%0t pulses exp=%h act=%h", $time, 0, led_q.size());
    end
    final_report();
  end

  initial begin : watchdog
    repeat (20000) @(negedge mclk);
    n_mismatch++;
    $display("[ERR] t=%0t watchdog exp=%h act=%h", $time, 0, 1);
    final_report();
  end
endmodule : testbench
`default_nettype wire
